// File: design/cclu_pkg.sv
// ============================================================
// shared constants and carriers of the custom logic unit
package cclu_pkg;
  localparam int NLUT = 6;

  // register indices, byte address is four times the index
  localparam logic [5:0] IDX_GLOBAL   = 6'h00;
  localparam logic [5:0] IDX_PAIR1    = 6'h02;
  localparam logic [5:0] IDX_PAIR2    = 6'h03;
  localparam logic [5:0] IDX_SENSE_LO = 6'h05;
  localparam logic [5:0] IDX_SENSE_HI = 6'h06;
  localparam logic [5:0] IDX_FLAGS    = 6'h07;
  localparam logic [5:0] IDX_LUT_BASE = 6'h08;
  localparam logic [5:0] IDX_LUT_END  = 6'h20;
  localparam logic [1:0] SUB_CTRL_A   = 2'h0;
  localparam logic [1:0] SUB_CTRL_B   = 2'h1;
  localparam logic [1:0] SUB_CTRL_C   = 2'h2;
  localparam logic [1:0] SUB_TRUTH    = 2'h3;
  localparam logic [7:0] REG_RESET    = 8'h00;

  // sequencer types
  localparam logic [3:0] SEQ_OFF    = 4'h0;
  localparam logic [3:0] SEQ_DFF    = 4'h1;
  localparam logic [3:0] SEQ_JK     = 4'h2;
  localparam logic [3:0] SEQ_DLATCH = 4'h3;
  localparam logic [3:0] SEQ_RS     = 4'h4;

  // interrupt sense
  localparam logic [1:0] SENSE_NONE = 2'h0;
  localparam logic [1:0] SENSE_RISE = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_BOTH = 2'h3;

  // output conditioning
  localparam logic [1:0] COND_NONE   = 2'h0;
  localparam logic [1:0] COND_SYNC   = 2'h1;
  localparam logic [1:0] COND_FILTER = 2'h2;

  // lut clock pick
  localparam logic [2:0] CLK_PERIPH     = 3'h0;
  localparam logic [2:0] CLK_INPUT2     = 3'h1;
  localparam logic [2:0] CLK_HF         = 3'h4;
  localparam logic [2:0] CLK_SLOW       = 3'h5;
  localparam logic [2:0] CLK_SLOW_DIV32 = 3'h6;

  // input source codes
  localparam logic [3:0] SRC_MASK       = 4'h0;
  localparam logic [3:0] SRC_FEEDBACK   = 4'h1;
  localparam logic [3:0] SRC_LINK       = 4'h2;
  localparam logic [3:0] SRC_EVENT_A    = 4'h3;
  localparam logic [3:0] SRC_EVENT_B    = 4'h4;
  localparam logic [3:0] SRC_PIN        = 4'h5;
  localparam logic [3:0] SRC_COMPARATOR = 4'h6;
  localparam logic [3:0] SRC_ZERO_CROSS = 4'h7;
  localparam logic [3:0] SRC_SERIAL_TX  = 4'h8;
  localparam logic [3:0] SRC_SPI        = 4'h9;
  localparam logic [3:0] SRC_TIMER_A0   = 4'ha;
  localparam logic [3:0] SRC_TIMER_A1   = 4'hb;
  localparam logic [3:0] SRC_TIMER_B    = 4'hc;
  localparam logic [3:0] SRC_TIMER_D0   = 4'hd;

  localparam logic [4:0] SLOW_DIV_LAST = 5'h1f;

  typedef struct packed {
    logic       edge_detect_on;
    logic       pin_drive_on;
    logic [1:0] output_conditioning;
    logic [2:0] lut_clock_pick;
    logic       lut_enable;
  } cclu_ctrl_a_t;

  typedef struct packed {
    logic [3:0] input1_source;
    logic [3:0] input0_source;
  } cclu_ctrl_b_t;

  typedef struct packed {
    cclu_ctrl_a_t a;
    cclu_ctrl_b_t b;
    logic [3:0]   input2_source;
    logic [7:0]   truth;
  } cclu_lut_cfg_t;

  // peripheral, pin and event signals feeding the luts
  typedef struct packed {
    logic [5:0]      event_a;
    logic [5:0]      event_b;
    logic [2:0][5:0] pin_in;
    logic [2:0]      comparator;
    logic [2:0]      zero_cross;
    logic [2:0]      serial_tx;
    logic            spi_mosi;
    logic            spi_sck;
    logic [2:0]      timer_a0_wo;
    logic [2:0]      timer_a1_wo;
    logic [2:0]      timer_b_wo;
    logic [2:0]      timer_d0_wo;
    logic            high_freq_oscillator;
    logic            slow_oscillator;
  } cclu_src_t;
endpackage

// File: design/cclu_lut_slice.sv
`timescale 1ns/1ps
// ============================================================
// one lut: truth lookup, clock pick, conditioning, edge detector
module cclu_lut_slice (
  input  logic                    pclk,
  input  logic                    presetn,
  input  logic                    active,
  input  cclu_pkg::cclu_lut_cfg_t cfg,
  input  logic [15:0]             opt0,
  input  logic [15:0]             opt1,
  input  logic [15:0]             opt2,
  input  logic                    hf_tick,
  input  logic                    slow_tick,
  input  logic                    div32_tick,
  output logic                    clk_en,
  output logic                    lut_cond
);
  typedef struct packed {
    logic       in2_prev;
    logic [1:0] sync;
    logic [1:0] hist;
    logic       filt;
    logic       edge_prev;
    logic       pulse;
  } cclu_slice_t;

  cclu_slice_t st;
  cclu_slice_t next_st;
  logic        in0;
  logic        in1;
  logic        in2;
  logic        raw;
  logic        cond;

  // input muxes; reserved codes select a zero bit
  assign in0 = opt0[cfg.b.input0_source];
  assign in1 = opt1[cfg.b.input1_source];
  assign in2 = opt2[cfg.input2_source];
  assign raw = cfg.truth[{in2, in1, in0}];

  // conditioning runs only on the picked lut clock
  always_comb begin
    next_st = st;
    next_st.in2_prev = in2;
    case (cfg.a.lut_clock_pick)
      cclu_pkg::CLK_PERIPH:     clk_en = 1'b1;
      cclu_pkg::CLK_INPUT2:     clk_en = in2 & ~st.in2_prev;
      cclu_pkg::CLK_HF:         clk_en = hf_tick;
      cclu_pkg::CLK_SLOW:       clk_en = slow_tick;
      cclu_pkg::CLK_SLOW_DIV32: clk_en = div32_tick;
      default:                  clk_en = 1'b0;
    endcase
    case (cfg.a.output_conditioning)
      cclu_pkg::COND_SYNC:   cond = st.sync[1];
      cclu_pkg::COND_FILTER: cond = st.filt;
      default:               cond = raw;
    endcase
    if (!active) begin
      next_st.sync = '0;
      next_st.hist = '0;
      next_st.filt = 1'b0;
      next_st.edge_prev = 1'b0;
      next_st.pulse = 1'b0;
    end else if (clk_en) begin
      next_st.sync = {st.sync[0], raw};
      next_st.hist = {st.hist[0], st.sync[1]};
      // filter passes a level only after three equal samples
      if (st.hist == {2{st.sync[1]}}) begin
        next_st.filt = st.sync[1];
      end
      next_st.edge_prev = cond;
      next_st.pulse = cond & ~st.edge_prev;
    end
    lut_cond = cfg.a.edge_detect_on ? st.pulse : cond;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

// File: design/cclu_top.sv
// Local design decision: the APB slave port.
`timescale 1ns/1ps
// ============================================================
module cclu_top (
  input  logic                pclk,
  input  logic                presetn,
  input  logic                psel,
  input  logic                penable,
  input  logic                pwrite,
  input  logic [7:0]          paddr,
  input  logic [31:0]         pwdata,
  input  logic [3:0]          pstrb,
  output logic [31:0]         prdata,
  output logic                pready,
  output logic                pslverr,
  input  cclu_pkg::cclu_src_t src,
  output logic [5:0]          lut_out,
  output logic [5:0]          lut_pin_level,
  output logic [5:0]          lut_pin_oe_n
);
  typedef struct packed {
    logic                              global_en;
    logic [3:0]                        pair1_seq;
    logic [3:0]                        pair2_seq;
    logic [7:0]                        sense_low;
    logic [3:0]                        sense_high;
    logic [5:0]                        flags;
    cclu_pkg::cclu_lut_cfg_t [5:0]     cfg;
    logic [5:0]                        lut_level;
    logic [5:0]                        pin_oe_n;
    logic [1:0]                        seq_q;
    logic                              hf_prev;
    logic                              slow_prev;
    logic [4:0]                        div_cnt;
    logic                              ack;
    logic                              err;
    logic [7:0]                        rdata;
  } cclu_state_t;

  localparam logic [5:0] IDX_LUT0_B = cclu_pkg::IDX_LUT_BASE + 6'(cclu_pkg::SUB_CTRL_B);

  cclu_state_t                   st;
  cclu_state_t                   next_st;
  logic [5:0]                    idx;
  logic [2:0]                    lut_n;
  logic [1:0]                    sub;
  logic                          in_lut;
  logic                          mapped;
  logic                          access;
  logic                          commit;
  logic                          wr;
  logic                          locked;
  logic [7:0]                    rd_val;
  logic                          hf_tick;
  logic                          slow_tick;
  logic                          div32_tick;
  logic [5:0]                    clk_en;
  logic [5:0]                    cond;
  logic [5:0]                    active;
  logic [5:0]                    final_lvl;
  logic [5:0]                    ev;
  logic [5:0]                    clr;
  logic [11:0]                   sense_all;
  logic [2:0][5:0][15:0]         opt;
  logic [3:0]                    seq_ty;
  logic                          seq_a;
  logic                          seq_b;
  logic                          seq_q;
  cclu_pkg::cclu_ctrl_a_t        wa;

  // ============================================================
  // apb decode; one wait state so read data comes from a flop
  assign idx    = paddr[7:2];
  assign sub    = idx[1:0];
  assign in_lut = (idx >= cclu_pkg::IDX_LUT_BASE) && (idx < cclu_pkg::IDX_LUT_END);
  assign lut_n  = 3'((idx - cclu_pkg::IDX_LUT_BASE) >> 2);
  assign access = psel & penable;
  assign commit = access & st.ack;
  assign wr     = commit & pwrite & pstrb[0];
  assign locked = st.cfg[lut_n].a.lut_enable;
  assign wa     = cclu_pkg::cclu_ctrl_a_t'(pwdata[7:0]);
  assign sense_all = {st.sense_high, st.sense_low};

  // bus outputs straight from state
  assign pready        = st.ack;
  assign pslverr       = st.ack & st.err;
  assign prdata        = {24'h000000, st.rdata};
  assign lut_out       = st.lut_level;
  assign lut_pin_level = st.lut_level;
  assign lut_pin_oe_n  = st.pin_oe_n;

  // read mux and map check; misaligned or unlisted words answer with an error
  always_comb begin
    rd_val = cclu_pkg::REG_RESET;
    mapped = 1'b1;
    if (|paddr[1:0]) begin
      mapped = 1'b0;
    end else if (in_lut) begin
      case (sub)
        cclu_pkg::SUB_CTRL_A: rd_val = st.cfg[lut_n].a;
        cclu_pkg::SUB_CTRL_B: rd_val = st.cfg[lut_n].b;
        cclu_pkg::SUB_CTRL_C: rd_val = {4'h0, st.cfg[lut_n].input2_source};
        default:              rd_val = st.cfg[lut_n].truth;
      endcase
    end else begin
      case (idx)
        cclu_pkg::IDX_GLOBAL:   rd_val = {7'h00, st.global_en};
        cclu_pkg::IDX_PAIR1:    rd_val = {4'h0, st.pair1_seq};
        cclu_pkg::IDX_PAIR2:    rd_val = {4'h0, st.pair2_seq};
        cclu_pkg::IDX_SENSE_LO: rd_val = st.sense_low;
        cclu_pkg::IDX_SENSE_HI: rd_val = {4'h0, st.sense_high};
        cclu_pkg::IDX_FLAGS:    rd_val = {2'h0, st.flags};
        default:                mapped = 1'b0;
      endcase
    end
  end

  // ============================================================
  // oscillator ticks; the slow divider makes the divide-by-32 pulse
  assign hf_tick    = src.high_freq_oscillator & ~st.hf_prev;
  assign slow_tick  = src.slow_oscillator & ~st.slow_prev;
  assign div32_tick = slow_tick && (st.div_cnt == cclu_pkg::SLOW_DIV_LAST);

  // ============================================================
  // source vectors; outputs come from flops so feedback and link have no loop
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      for (int n = 0; n < cclu_pkg::NLUT; n++) begin
        opt[k][n] = '0;
        opt[k][n][cclu_pkg::SRC_FEEDBACK]   = st.lut_level[n];
        opt[k][n][cclu_pkg::SRC_LINK]       = st.lut_level[(n + 1) % cclu_pkg::NLUT];
        opt[k][n][cclu_pkg::SRC_EVENT_A]    = src.event_a[n];
        opt[k][n][cclu_pkg::SRC_EVENT_B]    = src.event_b[n];
        opt[k][n][cclu_pkg::SRC_PIN]        = src.pin_in[k][n];
        opt[k][n][cclu_pkg::SRC_COMPARATOR] = src.comparator[k];
        opt[k][n][cclu_pkg::SRC_ZERO_CROSS] = src.zero_cross[k];
        opt[k][n][cclu_pkg::SRC_SERIAL_TX]  = src.serial_tx[k];
        opt[k][n][cclu_pkg::SRC_SPI]        = (k == 2) ? src.spi_sck : src.spi_mosi;
        opt[k][n][cclu_pkg::SRC_TIMER_A0]   = src.timer_a0_wo[k];
        opt[k][n][cclu_pkg::SRC_TIMER_A1]   = src.timer_a1_wo[k];
        opt[k][n][cclu_pkg::SRC_TIMER_B]    = src.timer_b_wo[k];
        opt[k][n][cclu_pkg::SRC_TIMER_D0]   = src.timer_d0_wo[k];
      end
    end
  end

  // ============================================================
  // six lut slices
  for (genvar g = 0; g < cclu_pkg::NLUT; g++) begin : g_lut
    assign active[g] = st.global_en & st.cfg[g].a.lut_enable;
    cclu_lut_slice u_slice (
      .pclk       (pclk),
      .presetn    (presetn),
      .active     (active[g]),
      .cfg        (st.cfg[g]),
      .opt0       (opt[0][g]),
      .opt1       (opt[1][g]),
      .opt2       (opt[2][g]),
      .hf_tick    (hf_tick),
      .slow_tick  (slow_tick),
      .div32_tick (div32_tick),
      .clk_en     (clk_en[g]),
      .lut_cond   (cond[g])
    );
  end

  // ============================================================
  // next state: bus, registers, sequencers, outputs and flags
  always_comb begin
    next_st = st;
    clr = '0;
    seq_ty = cclu_pkg::SEQ_OFF;
    seq_a = 1'b0;
    seq_b = 1'b0;
    seq_q = 1'b0;
    next_st.ack = access & ~st.ack;
    if (access & ~st.ack) begin
      next_st.rdata = rd_val;
      next_st.err = ~mapped;
    end
    next_st.hf_prev = src.high_freq_oscillator;
    next_st.slow_prev = src.slow_oscillator;
    if (slow_tick) begin
      next_st.div_cnt = st.div_cnt + 5'h01;
    end

    // register writes at the edge that completes the transfer
    if (wr && mapped) begin
      if (in_lut) begin
        case (sub)
          cclu_pkg::SUB_CTRL_A: begin
            if (locked) begin
              next_st.cfg[lut_n].a.lut_enable = wa.lut_enable;
            end else begin
              next_st.cfg[lut_n].a = wa;
            end
          end
          cclu_pkg::SUB_CTRL_B: begin
            if (!locked) begin
              next_st.cfg[lut_n].b = pwdata[7:0];
            end
          end
          cclu_pkg::SUB_CTRL_C: begin
            if (!locked) begin
              next_st.cfg[lut_n].input2_source = pwdata[3:0];
            end
          end
          default: begin
            if (!locked) begin
              next_st.cfg[lut_n].truth = pwdata[7:0];
            end
          end
        endcase
      end else begin
        case (idx)
          cclu_pkg::IDX_GLOBAL: next_st.global_en = pwdata[0];
          cclu_pkg::IDX_PAIR1: begin
            if (!st.global_en) begin
              next_st.pair1_seq = pwdata[3:0];
            end
          end
          cclu_pkg::IDX_PAIR2: begin
            if (!st.global_en) begin
              next_st.pair2_seq = pwdata[3:0];
            end
          end
          cclu_pkg::IDX_SENSE_LO: next_st.sense_low = pwdata[7:0];
          cclu_pkg::IDX_SENSE_HI: next_st.sense_high = pwdata[3:0];
          cclu_pkg::IDX_FLAGS:    clr = pwdata[5:0];
          default:                clr = '0;
        endcase
      end
    end

    // sequencers of pairs 1 and 2; pair 0 has none here
    final_lvl = cond;
    for (int p = 0; p < 2; p++) begin
      seq_ty = (p == 0) ? st.pair1_seq : st.pair2_seq;
      seq_a = cond[2 * p + 2];
      seq_b = cond[2 * p + 3];
      seq_q = st.seq_q[p];
      case (seq_ty)
        cclu_pkg::SEQ_DFF: begin
          if (clk_en[2 * p + 2]) begin
            seq_q = seq_b ? 1'b0 : seq_a;
          end
        end
        cclu_pkg::SEQ_JK: begin
          if (clk_en[2 * p + 2]) begin
            seq_q = (seq_a & ~st.seq_q[p]) | (~seq_b & st.seq_q[p]);
          end
        end
        cclu_pkg::SEQ_DLATCH: begin
          if (seq_b) begin
            seq_q = seq_a;
          end
        end
        cclu_pkg::SEQ_RS: begin
          if (seq_a ^ seq_b) begin
            seq_q = seq_a;
          end
        end
        default: seq_q = 1'b0;
      endcase
      next_st.seq_q[p] = st.global_en & seq_q;
      if (seq_ty != cclu_pkg::SEQ_OFF) begin
        final_lvl[2 * p + 2] = st.seq_q[p];
      end
    end

    // outputs, pin drive and edge flags; a set beats a same-cycle clear
    for (int n = 0; n < cclu_pkg::NLUT; n++) begin
      next_st.lut_level[n] = active[n] & final_lvl[n];
      next_st.pin_oe_n[n] = ~(active[n] & st.cfg[n].a.pin_drive_on);
      case (sense_all[2 * n +: 2])
        cclu_pkg::SENSE_RISE: ev[n] = next_st.lut_level[n] & ~st.lut_level[n];
        cclu_pkg::SENSE_FALL: ev[n] = ~next_st.lut_level[n] & st.lut_level[n];
        cclu_pkg::SENSE_BOTH: ev[n] = next_st.lut_level[n] ^ st.lut_level[n];
        default:              ev[n] = 1'b0;
      endcase
    end
    next_st.flags = (st.flags & ~clr) | ev;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.pin_oe_n <= '1;
    end else begin
      st <= next_st;
    end
  end

  // ============================================================
  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_rise0;
    st.sense_low[1:0] == cclu_pkg::SENSE_RISE && !st.lut_level[0] ##1 st.lut_level[0];
  endsequence

  sequence s_setup;
    psel && !penable ##1 psel && penable;
  endsequence

  AST_FLAG_RISE: assert property (
    s_rise0 |-> st.flags[0])
    else $error("rising lut 0 output did not set its flag");

  AST_FLAG_CLEAR: assert property (
    wr && mapped && idx == cclu_pkg::IDX_FLAGS && pwdata[0] && !ev[0] |=> !st.flags[0])
    else $error("write one did not clear flag 0");

  AST_FLAG_KEEP: assert property (
    wr && idx == cclu_pkg::IDX_FLAGS && !pwdata[1] && st.flags[1] |=> st.flags[1])
    else $error("write zero cleared flag 1");

  AST_SENSE_NONE: assert property (
    sense_all[3:2] == cclu_pkg::SENSE_NONE && !st.flags[1] |=> !st.flags[1])
    else $error("flag 1 set with sensing off");

  AST_LUT_OFF: assert property (
    !st.cfg[3].a.lut_enable |=> !st.lut_level[3])
    else $error("disabled lut 3 drives a one");

  AST_PROTECT_B: assert property (
    wr && idx == IDX_LUT0_B && st.cfg[0].a.lut_enable |=> $stable(st.cfg[0].b))
    else $error("control b of running lut 0 changed");

  AST_DFF_CAPTURE: assert property (
    st.pair1_seq == cclu_pkg::SEQ_DFF && st.global_en && clk_en[2] && !cond[3]
      |=> st.seq_q[0] == $past(cond[2]))
    else $error("pair 1 d flop missed its data");

  AST_PIN_DRIVE: assert property (
    active[4] && st.cfg[4].a.pin_drive_on |=> !lut_pin_oe_n[4] && lut_pin_level[4] == lut_out[4])
    else $error("lut 4 pin not driven");

  AST_APB_WAIT: assert property (
    s_setup |-> !pready ##1 pready)
    else $error("apb answer not on second access cycle");
endmodule

// File: dv/cclu_src_model.sv
`timescale 1ns/1ps
// ============================================================
// far side: peripheral, pin and event levels, synchronous to pclk
module cclu_src_model (
  input  logic                pclk,
  input  logic                presetn,
  input  logic [1:0]          cmd,
  output cclu_pkg::cclu_src_t src
);
  localparam int SRC_W = $bits(cclu_pkg::cclu_src_t);
  int seed = 52;

  // cmd: 0 hold, 1 fresh random levels, 2 all low, 3 all high
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src <= '0;
    end else begin
      case (cmd)
        2'h1: src <= SRC_W'({$random(seed), $random(seed)});
        2'h2: src <= '0;
        2'h3: src <= '1;
        default: src <= src;
      endcase
    end
  end
endmodule

// File: dv/cclu_top_test.sv
`timescale 1ns/1ps
// ============================================================
// bench: apb master, source model, lut and flag expectations
module cclu_top_test;
  logic                pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
  logic                penable = 1'b0, pwrite = 1'b0, err;
  logic [7:0]          paddr = 8'h00;
  logic [31:0]         pwdata = 32'h0, prdata, rd;
  logic                pready, pslverr;
  logic [5:0]          lut_out, lut_pin_level, lut_pin_oe_n;
  logic [1:0]          cmd = 2'h2;
  logic [7:0]          regs [7] = '{8'h08, 8'h0c, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24};
  cclu_pkg::cclu_src_t src;
  int                  fails = 0, comparisons = 0;

  always #20 pclk = ~pclk;

  cclu_src_model far (.pclk(pclk), .presetn(presetn), .cmd(cmd), .src(src));

  cclu_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src(src), .lut_out(lut_out),
    .lut_pin_level(lut_pin_level), .lut_pin_oe_n(lut_pin_oe_n));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 16) begin
      fails++;
      end_of_test();
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    check(rd, {24'h0, e}, "register");
  endtask

  // lut0 reconfigured while disabled, since enabled luts refuse writes other than to the lut_enable bit
  task automatic cfg(input logic [7:0] truth, input logic [7:0] b, input logic [7:0] a);
    apb(1'b1, 8'h20, 8'h00);
    apb(1'b1, 8'h2c, truth);
    apb(1'b1, 8'h24, b);
    apb(1'b1, 8'h20, a);
  endtask

  // expected lut0 input k for source code c
  function automatic logic pick(int c, int k);
    case (c)
      3: return src.event_a[0];
      4: return src.event_b[0];
      5: return src.pin_in[k][0];
      6: return src.comparator[k];
      7: return src.zero_cross[k];
      8: return src.serial_tx[k];
      9: return src.spi_mosi;
      10: return src.timer_a0_wo[k];
      11: return src.timer_a1_wo[k];
      12: return src.timer_b_wo[k];
      13: return src.timer_d0_wo[k];
      default: return 1'b0;
    endcase
  endfunction

  task automatic settle(input logic [1:0] c);
    cmd <= c;
    @(posedge pclk);
    cmd <= 2'h0;
    repeat (3) @(posedge pclk);
  endtask

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    foreach (regs[i]) rchk(regs[i], 8'h00);
    apb(1'b0, 8'h04, 8'h00);
    check(32'(err), 32'h1, "unmapped error");
    apb(1'b1, 8'h18, 8'h0f);
    rchk(8'h18, 8'h0f);
    $display("test registers done");
    apb(1'b1, 8'h00, 8'h01);
    for (int k = 0; k < 2; k++) begin
      for (int c = 0; c < (k ? 14 : 12); c++) begin
        if (c != 1 && c != 2) begin
          cfg(k ? 8'hcc : 8'haa, 8'(c << (4 * k)), 8'h01);
          repeat (2) begin
            settle(2'h1);
            check(lut_out[0], pick(c, k), "lut output");
          end
        end
      end
    end
    $display("test input sources done");
    cfg(8'haa, 8'h03, 8'h01);
    apb(1'b1, 8'h14, 8'h01);
    settle(2'h2);
    apb(1'b1, 8'h1c, 8'h3f);
    rchk(8'h1c, 8'h00);
    settle(2'h3);
    rchk(8'h1c, 8'h01);
    apb(1'b1, 8'h1c, 8'h00);
    rchk(8'h1c, 8'h01);
    apb(1'b1, 8'h1c, 8'h01);
    rchk(8'h1c, 8'h00);
    apb(1'b1, 8'h14, 8'h02);
    settle(2'h2);
    rchk(8'h1c, 8'h01);
    $display("test flags done");
    // each mode adds its own latency after the source rises
    settle(2'h2);
    cfg(8'haa, 8'h03, 8'h81);
    settle(2'h3);
    check(lut_out[0], 1'b1, "edge pulse");
    @(posedge pclk);
    check(lut_out[0], 1'b0, "edge pulse end");
    settle(2'h2);
    cfg(8'haa, 8'h03, 8'h11);
    settle(2'h3);
    check(lut_out[0], 1'b0, "sync delay");
    @(posedge pclk);
    check(lut_out[0], 1'b1, "sync output");
    settle(2'h2);
    cfg(8'haa, 8'h03, 8'h21);
    settle(2'h3);
    repeat (3) @(posedge pclk);
    check(lut_out[0], 1'b0, "filter delay");
    @(posedge pclk);
    check(lut_out[0], 1'b1, "filter output");
    $display("test conditioning done");
    cfg(8'haa, 8'h03, 8'h41);
    settle(2'h3);
    check(lut_pin_oe_n, 6'h3e, "pin enable");
    apb(1'b1, 8'h24, 8'h55);
    rchk(8'h24, 8'h03);
    apb(1'b1, 8'h20, 8'h80);
    rchk(8'h20, 8'h40);
    settle(2'h3);
    check(lut_out[0], 1'b0, "disabled lut");
    apb(1'b1, 8'h08, 8'h01);
    rchk(8'h08, 8'h00);
    apb(1'b1, 8'h00, 8'h00);
    apb(1'b1, 8'h08, 8'h03);
    apb(1'b1, 8'h0c, 8'h04);
    rchk(8'h08, 8'h03);
    rchk(8'h0c, 8'h04);
    // pair 1 as d flop: lut 2 data, lut 3 clears it
    apb(1'b1, 8'h08, 8'h01);
    apb(1'b1, 8'h4c, 8'haa);
    apb(1'b1, 8'h44, 8'h03);
    apb(1'b1, 8'h40, 8'h01);
    apb(1'b1, 8'h5c, 8'haa);
    apb(1'b1, 8'h54, 8'h04);
    apb(1'b1, 8'h50, 8'h01);
    apb(1'b1, 8'h00, 8'h01);
    repeat (2) begin
      settle(2'h1);
      check(lut_out[2], src.event_a[2] & ~src.event_b[3], "d flop");
    end
    $display("test protection done");
    end_of_test();
  end
endmodule
